// ---- verilog/ppw_cfg.svh ----
// Register map, field positions, reset values and timing of the pin wakeup.
`ifndef PPW_CFG_SVH
`define PPW_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define PPW_OFS_FILTER_ENABLE 16'h102d
`define PPW_OFS_TRIGGER_MODE 16'h102e
`define PPW_OFS_WAKEUP_RESET 16'h102f
`define PPW_RST_FILTER_ENABLE 8'h00
`define PPW_RST_TRIGGER_MODE 8'h00
`define PPW_RST_WAKEUP_RESET 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PPW_FILT_LSB 4
`define PPW_EN_LSB 0
`define PPW_T3_HI_EN_BIT 7
`define PPW_T3_LO_EN_BIT 6
`define PPW_T3_LO_FALL_MASK 4'hc

// ----------------------------------------------------------------------
// Trigger mode codes
// ----------------------------------------------------------------------
`define PPW_MODE_RISE 2'h0
`define PPW_MODE_FALL 2'h1
`define PPW_MODE_LVL1 2'h2
`define PPW_MODE_LVL2 2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PPW_CLK_PERIOD_NS 10
`define PPW_DEB_TIME_NS 1000
`define PPW_DEB_CYCLES \
  ((`PPW_DEB_TIME_NS + `PPW_CLK_PERIOD_NS - 1) / `PPW_CLK_PERIOD_NS)

`endif

// ---- verilog/ppw_pkg.sv ----
// Types shared by the pin wakeup modules.
`default_nettype none

package ppw_pkg;

  typedef logic [1:0] ppw_mode_t;

  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ppw_bus_s;

  typedef struct packed {
    logic trig;
    logic [3:0] cause;
  } ppw_evt_s;

  typedef enum logic {
    LVL_ARMED,
    LVL_SPENT
  } ppw_lvl_e;

endpackage

`default_nettype wire

// ---- verilog/ppw_sync_filter.sv ----
// Two-stage synchroniser and optional de-bounce for one pin nibble.
`include "ppw_cfg.svh"
`default_nettype none

module ppw_sync_filter (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_pins,
  input wire logic i_filter_en,
  output logic [3:0] o_level
);

  localparam logic [7:0] DEB_LAST = 8'(`PPW_DEB_CYCLES - 1);

  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] cand_ff;
  logic [7:0] cnt_ff;
  logic [3:0] level_ff;
  logic [7:0] nxt_cnt;
  logic [3:0] nxt_level;

  // ----------------------------------------------------------------------
  // Filter decision
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_cnt = 8'h00;
    nxt_level = level_ff;
    if (!i_filter_en)
    begin
      nxt_level = sync2_ff;
    end
    else if (sync2_ff == cand_ff)
    begin
      if (cnt_ff >= DEB_LAST)
      begin
        nxt_level = cand_ff;
        nxt_cnt = cnt_ff;
      end
      else
      begin
        nxt_cnt = cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      cand_ff <= 4'h0;
      cnt_ff <= 8'h00;
      level_ff <= 4'h0;
    end
    else
    begin
      sync1_ff <= i_pins;
      sync2_ff <= sync1_ff;
      cand_ff <= sync2_ff;
      cnt_ff <= nxt_cnt;
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  filter_bypass_a: assert property (
    !i_filter_en |=> level_ff == $past(sync2_ff))
    else $error("unfiltered level does not follow the synchroniser");

  debounce_hold_a: assert property (
    i_filter_en && $past(i_filter_en) && level_ff != $past(level_ff)
      |-> $past(cnt_ff) >= DEB_LAST)
    else $error("filtered level changed before the stable count");

endmodule

`default_nettype wire

// ---- verilog/ppw_nibble_detect.sv ----
// Trigger detection for one nibble in one of the four trigger modes.
`include "ppw_cfg.svh"
`default_nettype none

module ppw_nibble_detect (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_level,
  input wire logic i_en,
  input wire ppw_pkg::ppw_mode_t i_mode,
  input wire logic [3:0] i_fall_mask,
  input wire logic i_setup,
  output ppw_pkg::ppw_evt_s o_evt
);

  logic [3:0] prev_ff;
  logic [3:0] ref_ff;
  logic en_d_ff;
  ppw_pkg::ppw_lvl_e state_ff;
  ppw_pkg::ppw_lvl_e nxt_state;
  ppw_pkg::ppw_evt_s evt_ff;
  ppw_pkg::ppw_evt_s nxt_evt;

  wire setup = i_setup | (i_en & ~en_d_ff);
  wire [3:0] fall_sel = {4{i_mode == `PPW_MODE_FALL}} ^ i_fall_mask;
  wire [3:0] rise_bits = i_level & ~prev_ff;
  wire [3:0] fall_bits = ~i_level & prev_ff;
  wire [3:0] edge_bits = (rise_bits & ~fall_sel) | (fall_bits & fall_sel);
  wire [3:0] diff_ref = i_level ^ ref_ff;
  wire [3:0] diff_prev = i_level ^ prev_ff;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_evt = '0;
    unique case (i_mode)
      `PPW_MODE_RISE, `PPW_MODE_FALL:
      begin
        nxt_evt.cause = edge_bits;
      end
      `PPW_MODE_LVL1:
      begin
        if (state_ff == ppw_pkg::LVL_ARMED && diff_ref != 4'h0)
        begin
          nxt_evt.cause = diff_ref;
          nxt_state = ppw_pkg::LVL_SPENT;
        end
        else if (state_ff == ppw_pkg::LVL_SPENT && diff_ref == 4'h0)
        begin
          nxt_state = ppw_pkg::LVL_ARMED;
        end
      end
      `PPW_MODE_LVL2:
      begin
        nxt_evt.cause = diff_prev;
      end
    endcase
    if (setup || !i_en)
    begin
      nxt_state = ppw_pkg::LVL_ARMED;
      nxt_evt.cause = 4'h0;
    end
    nxt_evt.trig = |nxt_evt.cause;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      prev_ff <= 4'h0;
      ref_ff <= 4'h0;
      en_d_ff <= 1'b0;
      state_ff <= ppw_pkg::LVL_ARMED;
      evt_ff <= '0;
    end
    else
    begin
      prev_ff <= i_level;
      ref_ff <= setup ? i_level : ref_ff;
      en_d_ff <= i_en;
      state_ff <= nxt_state;
      evt_ff <= nxt_evt;
    end
  end

  assign o_evt = evt_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  lvl1_once_a: assert property (
    i_mode == `PPW_MODE_LVL1 && state_ff == ppw_pkg::LVL_SPENT
      |=> !evt_ff.trig)
    else $error("mode one fired twice before returning");

  lvl1_rearm_a: assert property (
    i_mode == `PPW_MODE_LVL1 && state_ff == ppw_pkg::LVL_SPENT
      && i_level == ref_ff |=> state_ff == ppw_pkg::LVL_ARMED)
    else $error("mode one did not re-arm on return");

  lvl2_change_a: assert property (
    i_mode == `PPW_MODE_LVL2 && i_en && en_d_ff && !i_setup
      && i_level != prev_ff |=> evt_ff.trig)
    else $error("mode two missed a change");

  lvl2_quiet_a: assert property (
    i_mode == `PPW_MODE_LVL2 && i_level == prev_ff |=> !evt_ff.trig)
    else $error("mode two fired without a change");

  edge_dir_a: assert property (
    i_mode == `PPW_MODE_RISE && i_fall_mask == 4'h0 && nxt_evt.trig
      |-> (i_level & ~prev_ff) != 4'h0)
    else $error("rising mode fired without a rising pin");

endmodule

`default_nettype wire

// ---- verilog/ppw_top.sv ----
// Port pin interrupt and wakeup detection with its three control registers.
//
// How it works
// - Filter bits 7:4 select de-bounce per first and second port nibble; third port is never filtered.
// - Enable bits 3:0 gate nibble triggers.
// - Two mode bits per nibble pick trigger.
// - Mode one fires once, leaving the reference.
// - Mode one re-arms when nibble returns.
// - Mode two fires on every nibble change.
// - Third high nibble: bit 7, rising edges.
// - Third low nibble: bit 6, mixed edges.
// - Bit 5 adds reset to third high wake.
// - Bits 4:0 select reset for other nibbles.
// - Firing nibble sets its causing pin flags.
`include "ppw_cfg.svh"
`default_nettype none

module ppw_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire ppw_pkg::ppw_bus_s i_bus,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_first_port,
  input wire logic [7:0] i_second_port,
  input wire logic [7:0] i_third_port,
  input wire logic [7:0] i_first_port_flag_clr,
  input wire logic [7:0] i_second_port_flag_clr,
  input wire logic [7:0] i_third_port_flag_clr,
  output logic [7:0] o_first_port_flag,
  output logic [7:0] o_second_port_flag,
  output logic [7:0] o_third_port_flag,
  output logic [5:0] o_nibble_event,
  output logic o_wake,
  output logic o_wake_reset
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [15:0] addr,
                                    input logic [15:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  wire hit_filt = addr_hit(i_bus.addr, `PPW_OFS_FILTER_ENABLE);
  wire hit_mode = addr_hit(i_bus.addr, `PPW_OFS_TRIGGER_MODE);
  wire hit_wrst = addr_hit(i_bus.addr, `PPW_OFS_WAKEUP_RESET);
  wire wr_filt = i_bus.wr & hit_filt;
  wire wr_mode = i_bus.wr & hit_mode;
  wire wr_wrst = i_bus.wr & hit_wrst;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic [7:0] filt_en_ff;
  logic [7:0] mode_ff;
  logic [7:0] wrst_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (i_bus.rd)
    begin
      nxt_rdata = hit_filt ? filt_en_ff :
                  hit_mode ? mode_ff :
                  hit_wrst ? wrst_ff : 8'h00;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      filt_en_ff <= `PPW_RST_FILTER_ENABLE;
      mode_ff <= `PPW_RST_TRIGGER_MODE;
      wrst_ff <= `PPW_RST_WAKEUP_RESET;
      rdata_ff <= 8'h00;
    end
    else
    begin
      filt_en_ff <= wr_filt ? i_bus.wdata : filt_en_ff;
      mode_ff <= wr_mode ? i_bus.wdata : mode_ff;
      wrst_ff <= wr_wrst ? i_bus.wdata : wrst_ff;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  // ----------------------------------------------------------------------
  // Per nibble configuration
  // ----------------------------------------------------------------------
  // Nibble index: 0 first low, 1 first high, 2 second low, 3 second high,
  // 4 third low, 5 third high.
  wire [23:0] pins_all = {i_third_port, i_second_port, i_first_port};
  wire [5:0] nib_en = {wrst_ff[`PPW_T3_HI_EN_BIT],
                       wrst_ff[`PPW_T3_LO_EN_BIT],
                       filt_en_ff[`PPW_EN_LSB +: 4]};
  wire [5:0] nib_filt = {2'b00, filt_en_ff[`PPW_FILT_LSB +: 4]};
  wire [11:0] nib_mode = {`PPW_MODE_RISE,
                          `PPW_MODE_RISE,
                          mode_ff};
  wire [23:0] nib_fall_mask = {4'h0, `PPW_T3_LO_FALL_MASK, 16'h0000};
  wire nib_setup = wr_mode | wr_filt | wr_wrst;

  logic [23:0] nib_level;
  logic [5:0] nib_trig;
  logic [23:0] nib_cause;

  // ----------------------------------------------------------------------
  // Detection chain per nibble
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : g_nib
      ppw_pkg::ppw_evt_s evt;

      ppw_sync_filter u_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pins(pins_all[4*g +: 4]),
        .i_filter_en(nib_filt[g]),
        .o_level(nib_level[4*g +: 4])
      );

      ppw_nibble_detect u_detect (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_level(nib_level[4*g +: 4]),
        .i_en(nib_en[g]),
        .i_mode(nib_mode[2*g +: 2]),
        .i_fall_mask(nib_fall_mask[4*g +: 4]),
        .i_setup(nib_setup),
        .o_evt(evt)
      );

      assign nib_trig[g] = evt.trig;
      assign nib_cause[4*g +: 4] = evt.cause;
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Pin flags and wake outputs
  // ----------------------------------------------------------------------
  logic [23:0] flag_ff;
  logic [5:0] event_ff;
  logic wake_ff;
  logic wake_reset_ff;

  wire [23:0] flag_clr = {i_third_port_flag_clr,
                          i_second_port_flag_clr,
                          i_first_port_flag_clr};
  wire [23:0] nxt_flag = (flag_ff & ~flag_clr) | nib_cause;
  wire nxt_wake = |nib_trig;
  wire nxt_wake_reset = |(nib_trig & wrst_ff[5:0]);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      flag_ff <= 24'h000000;
      event_ff <= 6'h00;
      wake_ff <= 1'b0;
      wake_reset_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
      event_ff <= nib_trig;
      wake_ff <= nxt_wake;
      wake_reset_ff <= nxt_wake_reset;
    end
  end

  assign o_first_port_flag = flag_ff[7:0];
  assign o_second_port_flag = flag_ff[15:8];
  assign o_third_port_flag = flag_ff[23:16];
  assign o_nibble_event = event_ff;
  assign o_wake = wake_ff;
  assign o_wake_reset = wake_reset_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_fire;
    nib_trig != 6'h00;
  endsequence

  sequence s_wake_out;
    o_wake && o_nibble_event == $past(nib_trig);
  endsequence

  no_fire_off_a: assert property (
    nib_trig != 6'h00 |-> (nib_trig & ~$past(nib_en)) == 6'h00)
    else $error("disabled nibble raised a trigger");

  wake_follow_a: assert property (
    s_fire |=> s_wake_out)
    else $error("trigger did not wake");

  wake_reset_sel_a: assert property (
    s_fire ##1 1'b1 |-> o_wake_reset ==
      |($past(nib_trig) & $past(wrst_ff[5:0])))
    else $error("wake reset does not match its select");

  reset_needs_wake_a: assert property (
    o_wake_reset |-> o_wake)
    else $error("reset raised without a wake");

  flag_set_a: assert property (
    s_fire |=> (flag_ff & $past(nib_cause)) == $past(nib_cause))
    else $error("causing pin flag not set");

  third_hi_rise_a: assert property (
    nib_trig[5] |-> (nib_cause[23:20] & ~$past(nib_level[23:20])) == 4'h0)
    else $error("third high nibble fired on a falling pin");

  third_lo_mix_a: assert property (
    nib_trig[4] |->
      (nib_cause[17:16] & ~$past(nib_level[17:16])) == 2'b00
      && (nib_cause[19:18] & $past(nib_level[19:18])) == 2'b00)
    else $error("third low nibble fired on the wrong edge");

  reg_write_a: assert property (
    wr_mode |=> mode_ff == $past(i_bus.wdata))
    else $error("mode register did not take the write");

  // ----------------------------------------------------------------------
  // Register, flag and quiet checks
  // ----------------------------------------------------------------------
  sequence s_quiet;
    nib_trig == 6'h00;
  endsequence

  flag_clear_a: assert property (
    1'b1 |=> (flag_ff & $past(flag_clr & ~nib_cause)) == 24'h000000)
    else $error("cleared pin flag stayed set");

  flag_sticky_a: assert property (
    1'b1 |=> ($past(flag_ff & ~flag_clr) & ~flag_ff) == 24'h000000)
    else $error("pin flag dropped without a clear");

  flag_cause_a: assert property (
    1'b1 |=> (flag_ff & ~$past(flag_ff) & ~$past(nib_cause)) == 24'h000000)
    else $error("pin flag set without a cause");

  wake_idle_a: assert property (
    nib_trig == 6'h00 |=> !o_wake)
    else $error("wake raised without a trigger");

  wake_rst_off_a: assert property (
    (nib_trig & wrst_ff[5:0]) == 6'h00 |=> !o_wake_reset)
    else $error("wake reset raised with its select clear");

  setup_quiet_a: assert property (
    nib_setup |=> s_quiet)
    else $error("trigger raised in a setup cycle");

  third_hi_off_a: assert property (
    !wrst_ff[`PPW_T3_HI_EN_BIT] |=> !nib_trig[5])
    else $error("disabled third high nibble fired");

  third_lo_off_a: assert property (
    !wrst_ff[`PPW_T3_LO_EN_BIT] |=> !nib_trig[4])
    else $error("disabled third low nibble fired");

  rdata_filt_a: assert property (
    i_bus.rd && hit_filt |=> o_rdata == $past(filt_en_ff))
    else $error("filter register read back wrong");

  rdata_mode_a: assert property (
    i_bus.rd && hit_mode |=> o_rdata == $past(mode_ff))
    else $error("mode register read back wrong");

  rdata_wrst_a: assert property (
    i_bus.rd && hit_wrst |=> o_rdata == $past(wrst_ff))
    else $error("wakeup reset register read back wrong");

  rdata_unmap_a: assert property (
    i_bus.rd && !hit_filt && !hit_mode && !hit_wrst |=> o_rdata == 8'h00)
    else $error("unmapped read gave nonzero data");

  filt_write_a: assert property (
    wr_filt |=> filt_en_ff == $past(i_bus.wdata))
    else $error("filter register did not take the write");

  wrst_write_a: assert property (
    wr_wrst |=> wrst_ff == $past(i_bus.wdata))
    else $error("wakeup reset register did not take the write");

  filt_keep_a: assert property (
    !wr_filt |=> $stable(filt_en_ff))
    else $error("filter register changed without a write");

  mode_keep_a: assert property (
    !wr_mode |=> $stable(mode_ff))
    else $error("mode register changed without a write");

  wrst_keep_a: assert property (
    !wr_wrst |=> $stable(wrst_ff))
    else $error("wakeup reset register changed without a write");

endmodule

`default_nettype wire

// ---- sim/ppw_pin_model.sv ----
// Pin driver that stands in for the outside world on all three ports.
`default_nettype none

module ppw_pin_model (
  input wire logic i_clk,
  input wire logic [23:0] i_want,
  input wire logic i_bounce,
  output logic [23:0] o_pins
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_pins = 24'h000000;

  // A bouncing contact flips the first low nibble on every cycle.
  always @(negedge i_clk)
  begin
    o_pins <= i_bounce ? {i_want[23:4], ~o_pins[3:0]} : i_want;
  end
endmodule

`default_nettype wire

// ---- sim/test_ppw_top.sv ----
// Self-checking bench for the port pin interrupt and wakeup block.
`include "ppw_cfg.svh"
`default_nettype none

module test_ppw_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  ppw_pkg::ppw_bus_s bus = '0;
  logic [7:0] rdata, fl1, fl2, fl3;
  logic [23:0] want = 24'h0;
  logic [23:0] pins;
  logic [23:0] clr = 24'h0;
  logic bounce = 1'b0;
  logic [5:0] evt;
  logic wake, wake_rst;
  logic [5:0] ev_acc = 6'h0;
  int wk_n = 0;
  int wr_n = 0;
  int error_cnt = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h806c;
  logic [7:0] rf = 8'h0;
  logic [7:0] rm = 8'h0;
  logic [7:0] rw = 8'h0;
  logic [3:0] lv [6] = '{default: 4'h0};
  logic [3:0] refv [6] = '{default: 4'h0};
  logic [5:0] spent = 6'h0;
  logic [23:0] exp_fl = 24'h0;
  logic [3:0] seq1 [5] = '{4'he, 4'ha, 4'h0, 4'hf, 4'hb};
  logic [3:0] seq2 [6] = '{4'hf, 4'he, 4'ha, 4'ha, 4'hb, 4'hf};

  always #5 i_clk = ~i_clk;

  ppw_pin_model u_pins (.i_clk(i_clk), .i_want(want), .i_bounce(bounce),
    .o_pins(pins));

  ppw_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus),
    .o_rdata(rdata), .i_first_port(pins[7:0]),
    .i_second_port(pins[15:8]), .i_third_port(pins[23:16]),
    .i_first_port_flag_clr(clr[7:0]), .i_second_port_flag_clr(clr[15:8]),
    .i_third_port_flag_clr(clr[23:16]), .o_first_port_flag(fl1),
    .o_second_port_flag(fl2), .o_third_port_flag(fl3),
    .o_nibble_event(evt), .o_wake(wake), .o_wake_reset(wake_rst));

  always @(posedge i_clk)
  begin
    ev_acc = ev_acc | evt;
    if (wake !== 1'b0)
      wk_n++;
    if (wake_rst !== 1'b0)
      wr_n++;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [3:0] edge_c(input logic [3:0] o,
    input logic [3:0] n, input logic [3:0] rmask, input logic [3:0] fmask);
    return (~o & n & rmask) | (o & ~n & fmask);
  endfunction

  task automatic chk(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge i_clk);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = 1'b1;
    @(negedge i_clk);
    bus.wr = 1'b0;
    if (a == `PPW_OFS_FILTER_ENABLE)
      rf = d;
    if (a == `PPW_OFS_TRIGGER_MODE)
      rm = d;
    if (a == `PPW_OFS_WAKEUP_RESET)
      rw = d;
    if (a >= `PPW_OFS_FILTER_ENABLE && a <= `PPW_OFS_WAKEUP_RESET)
    begin
      refv = lv;
      spent = 6'h0;
    end
  endtask

  task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge i_clk);
    bus.addr = a;
    bus.rd = 1'b1;
    @(negedge i_clk);
    bus.rd = 1'b0;
    chk("rdata", {16'h0, e}, {16'h0, rdata});
  endtask

  task automatic clear_flags();
    @(negedge i_clk);
    clr = 24'hffffff;
    @(negedge i_clk);
    clr = 24'h0;
    exp_fl = 24'h0;
  endtask

  task automatic step(input logic [23:0] nw, input int cyc);
    logic [3:0] o, n, c;
    logic [1:0] md;
    logic [5:0] ev;
    logic rs;
    int k;
    ev = 6'h0;
    rs = 1'b0;
    @(negedge i_clk);
    want = nw;
    ev_acc = 6'h0;
    wk_n = 0;
    wr_n = 0;
    for (k = 0; k < 6; k++)
    begin
      o = lv[k];
      n = nw[4*k+:4];
      md = (k < 4) ? rm[2*k+:2] : 2'h0;
      case (md)
        2'h0: c = edge_c(o, n, (k == 4) ? 4'h3 : 4'hf, (k == 4) ? 4'hc : 4'h0);
        2'h1: c = edge_c(o, n, 4'h0, 4'hf);
        2'h2: c = spent[k] ? 4'h0 : (n ^ refv[k]);
        default: c = n ^ o;
      endcase
      if (md == 2'h2)
        spent[k] = (n != refv[k]);
      if (((k < 4) ? rf[k] : rw[k + 2]) && c != 4'h0)
      begin
        ev[k] = 1'b1;
        rs = rs | rw[k];
        exp_fl[4*k+:4] = exp_fl[4*k+:4] | c;
      end
      lv[k] = n;
    end
    repeat (cyc) @(negedge i_clk);
    chk("events", {18'h0, ev}, {18'h0, ev_acc});
    chk("wake", {23'h0, |ev}, wk_n[23:0]);
    chk("wake reset", {23'h0, rs}, wr_n[23:0]);
    chk("flags", exp_fl, {fl3, fl2, fl1});
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    reg_rd(`PPW_OFS_FILTER_ENABLE, `PPW_RST_FILTER_ENABLE);
    reg_rd(`PPW_OFS_TRIGGER_MODE, `PPW_RST_TRIGGER_MODE);
    reg_rd(`PPW_OFS_WAKEUP_RESET, `PPW_RST_WAKEUP_RESET);
    reg_wr(16'h1030, 8'hff);
    reg_rd(16'h1030, 8'h00);
    reg_rd(`PPW_OFS_WAKEUP_RESET, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      seed = xs(seed);
      reg_wr(16'h102d + 16'(i), seed[7:0]);
      reg_rd(16'h102d + 16'(i), seed[7:0]);
    end
    reg_wr(`PPW_OFS_FILTER_ENABLE, 8'h00);
    step(24'h00000f, 12);
    reg_wr(`PPW_OFS_WAKEUP_RESET, 8'h01);
    reg_wr(`PPW_OFS_TRIGGER_MODE, 8'h02);
    reg_wr(`PPW_OFS_FILTER_ENABLE, 8'h01);
    foreach (seq1[i])
      step({20'h0, seq1[i]}, 12);
    reg_wr(`PPW_OFS_TRIGGER_MODE, 8'h03);
    foreach (seq2[i])
      step({20'h0, seq2[i]}, 12);
    reg_wr(`PPW_OFS_FILTER_ENABLE, 8'h11);
    @(negedge i_clk);
    ev_acc = 6'h0;
    want[3:0] = 4'h5;
    bounce = 1'b1;
    repeat (60) @(negedge i_clk);
    bounce = 1'b0;
    repeat (`PPW_DEB_CYCLES - 10) @(negedge i_clk);
    chk("filtered", 24'h0, {18'h0, ev_acc});
    step(want, 30);
    for (int i = 0; i < 240; i++)
    begin
      seed = xs(seed);
      if (i % 24 == 0)
      begin
        reg_wr(`PPW_OFS_FILTER_ENABLE, {4'h0, seed[3:0]});
        reg_wr(`PPW_OFS_TRIGGER_MODE, seed[15:8]);
        reg_wr(`PPW_OFS_WAKEUP_RESET, seed[31:24]);
        seed = xs(seed);
      end
      if (i % 7 == 6)
        clear_flags();
      step(seed[23:0], 12);
    end
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk("flags after reset", 24'h0, {fl3, fl2, fl1});
    reg_rd(`PPW_OFS_TRIGGER_MODE, `PPW_RST_TRIGGER_MODE);
    report_and_stop();
  end

  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule

`default_nettype wire
